// File: lcdp_pkg.sv
// Package for the LCD power control register bank.
// Assumes an 8-bit special function register bus on one clock, mclk.
package lcdp_pkg;

   // Register addresses on the special function register bus
   localparam logic [7:0] ADDR_PWR = 8'ha4;
   localparam logic [7:0] ADDR_VBM = 8'ha6;
   localparam logic [7:0] ADDR_AUX = 8'ha7;
   localparam logic [7:0] ADDR_MSCN = 8'hab;
   localparam logic [7:0] ADDR_MSCF = 8'hac;
   localparam logic [7:0] SEG_BASE = 8'h90;
   localparam int SEG_COUNT = 16;

   // Reset values
   localparam logic [7:0] RST_MSCN = 8'h20;
   localparam logic [7:0] RST_MSCF = 8'hfe;
   localparam logic [7:0] RST_PWR = 8'h09;
   localparam logic [7:0] RST_VBM = 8'h00;
   localparam logic [7:0] RST_AUX = 8'h00;
   localparam logic [7:0] SEG_CLEAR = 8'h00;

   // Master control field positions
   localparam int MSCN_ON = 0;
   localparam int MSCN_CLR = 1;
   localparam int MSCN_PUMP_LOW_DRIVE = 2;
   localparam int MSCN_CLKOE = 4;
   localparam int MSCN_DCBIAS = 5;
   localparam int MSCN_BIAS = 6;
   // Bits that hold storage; 7 and 3 always read zero
   localparam logic [7:0] MSCN_MASK = 8'h77;

   // Master configuration field positions and fixed ones above them
   localparam int MSCF_BYP = 0;
   localparam int MSCF_BUCK = 1;
   localparam logic [7:0] MSCF_FIXED = 8'hfc;

   // Power register: mode bit, fixed low field, upper nibble zero
   localparam int PWR_MODE = 3;
   localparam logic [7:0] PWR_FIXED = 8'h01;

   // Monitor control: enable, link to contrast, threshold field
   localparam int VBM_EN = 7;
   localparam int VBM_LINK = 6;
   localparam logic [7:0] VBM_MASK = 8'hdf;
   localparam int THR_W = 5;

   // Auxiliary register: offset steps and wake-up select
   localparam int OFS_W = 3;
   localparam int AUX_WAKE = 4;
   localparam logic [7:0] AUX_MASK = 8'h17;

   // Threshold offset step and top threshold code
   localparam int OFS_STEP_MV = 60;
   localparam logic [5:0] THR_MAX = 6'h1f;

endpackage

// File: lcdp_seg_if.sv
// Carrier between the control registers and the segment data store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lcdp_seg_if #(
   parameter int IDXW = 4
);
   logic wr;
   logic clr;
   logic [IDXW-1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctl (
      output wr,
      output clr,
      output idx,
      output wdata,
      input rdata
   );
   modport seg (
      input wr,
      input clr,
      input idx,
      input wdata,
      output rdata
   );
endinterface
`default_nettype wire

// File: lcdp_seg_store.sv
// Segment data store: one byte per entry, written by index.
// Assumes the control block decodes the bus and drives clear.
`timescale 1ns/1ps
`default_nettype none
module lcdp_seg_store #(
   parameter int SEG_COUNT = lcdp_pkg::SEG_COUNT,
   parameter int IDXW = 4
) (
   input wire logic mclk,
   input wire logic rst,
   lcdp_seg_if.seg bus,
   output logic [SEG_COUNT*8-1:0] seg_flat
);
   typedef struct packed {
      logic [SEG_COUNT-1:0][7:0] data;
   } lcdp_seg_st_t;

   lcdp_seg_st_t st_r;
   lcdp_seg_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < SEG_COUNT; i++) begin
         // Clear wins over a write in the same cycle
         if (bus.clr) begin
            st_nxt.data[i] = lcdp_pkg::SEG_CLEAR;
         end else if (bus.wr && (int'(bus.idx) == i)) begin
            st_nxt.data[i] = bus.wdata;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.rdata = st_r.data[bus.idx];
   assign seg_flat = st_r.data;

   clear_empty_a: assert property (
      @(posedge mclk) disable iff (rst)
      bus.clr |=> (seg_flat == '0))
      else $error("segment data not zero after clear");
endmodule
`default_nettype wire

// File: lcdp_regs.sv
// LCD power control register bank with segment data store.
// Assumes a single-cycle special function register bus on mclk;
// batt_low comes from the analog monitor, outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module lcdp_regs #(
   parameter int SEG_COUNT = lcdp_pkg::SEG_COUNT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [4:0] contrast_code,
   input wire logic batt_low,
   output logic display_on,
   output logic display_clear,
   output logic pump_low_drive,
   output logic lcd_clk_on,
   output logic bias_on,
   output logic dc_bias_out,
   output logic bias_gen_on,
   output logic buck_sleep_keep,
   output logic pump_bypass,
   output logic contrast_mode_hi,
   output logic mon_enable,
   output logic thr_linked,
   output logic [4:0] mon_threshold,
   output logic wake_req,
   output logic [SEG_COUNT*8-1:0] seg_data
);
   localparam int IDXW = (SEG_COUNT > 1) ? $clog2(SEG_COUNT) : 1;

   typedef struct packed {
      logic [7:0] mscn;
      logic [1:0] mscf;
      logic mode;
      logic [7:0] vbm;
      logic [7:0] aux;
      logic [7:0] rdata;
      logic low_meta;
      logic low_sync;
      logic [4:0] thr_eff;
      logic wake;
      logic gen_on;
   } lcdp_state_t;

   lcdp_state_t st_r;
   lcdp_state_t st_nxt;

   lcdp_seg_if #(.IDXW(IDXW)) seg_bus ();

   logic wr_mscn;
   logic wr_mscf;
   logic wr_pwr;
   logic wr_vbm;
   logic wr_aux;
   logic seg_hit;
   logic [7:0] seg_off;
   logic [5:0] thr_sum;

   assign wr_mscn = sfr_wr && (sfr_addr == lcdp_pkg::ADDR_MSCN);
   assign wr_mscf = sfr_wr && (sfr_addr == lcdp_pkg::ADDR_MSCF);
   assign wr_pwr = sfr_wr && (sfr_addr == lcdp_pkg::ADDR_PWR);
   assign wr_vbm = sfr_wr && (sfr_addr == lcdp_pkg::ADDR_VBM);
   assign wr_aux = sfr_wr && (sfr_addr == lcdp_pkg::ADDR_AUX);
   assign seg_off = sfr_addr - lcdp_pkg::SEG_BASE;
   assign seg_hit = (sfr_addr >= lcdp_pkg::SEG_BASE) &&
                    (int'(seg_off) < SEG_COUNT);

   // The clear acts on the write edge itself so that the very next
   // access already sees zero, and keeps acting while the bit is held
   assign seg_bus.clr = st_r.mscn[lcdp_pkg::MSCN_CLR] ||
                        (wr_mscn && sfr_wdata[lcdp_pkg::MSCN_CLR]);
   assign seg_bus.wr = sfr_wr && seg_hit;
   assign seg_bus.idx = seg_off[IDXW-1:0];
   assign seg_bus.wdata = sfr_wdata;

   // Linked threshold: contrast code plus offset, saturated at the top
   assign thr_sum = {1'b0, contrast_code} +
                    {3'b000, st_r.aux[lcdp_pkg::OFS_W-1:0]};

   always_comb begin
      st_nxt = st_r;

      // Storage only where bits exist; reserved bits never latch
      if (wr_mscn) begin
         st_nxt.mscn = sfr_wdata & lcdp_pkg::MSCN_MASK;
      end
      if (wr_mscf) begin
         st_nxt.mscf = sfr_wdata[1:0];
      end
      if (wr_pwr) begin
         st_nxt.mode = sfr_wdata[lcdp_pkg::PWR_MODE];
      end
      if (wr_vbm) begin
         st_nxt.vbm = sfr_wdata & lcdp_pkg::VBM_MASK;
      end
      if (wr_aux) begin
         st_nxt.aux = sfr_wdata & lcdp_pkg::AUX_MASK;
      end

      // Read data is captured on the read strobe and held after it
      if (sfr_rd) begin
         case (sfr_addr)
            lcdp_pkg::ADDR_MSCN: begin
               st_nxt.rdata = st_r.mscn & lcdp_pkg::MSCN_MASK;
            end
            lcdp_pkg::ADDR_MSCF: begin
               st_nxt.rdata = lcdp_pkg::MSCF_FIXED |
                              {6'h00, st_r.mscf};
            end
            lcdp_pkg::ADDR_PWR: begin
               st_nxt.rdata = lcdp_pkg::PWR_FIXED |
                              {4'h0, st_r.mode, 3'h0};
            end
            lcdp_pkg::ADDR_VBM: begin
               st_nxt.rdata = st_r.vbm & lcdp_pkg::VBM_MASK;
            end
            lcdp_pkg::ADDR_AUX: begin
               st_nxt.rdata = st_r.aux & lcdp_pkg::AUX_MASK;
            end
            default: begin
               // Unmapped addresses read zero
               st_nxt.rdata = seg_hit ? seg_bus.rdata : 8'h00;
            end
         endcase
      end

      // Battery-low level crosses in through two flip-flops
      st_nxt.low_meta = batt_low;
      st_nxt.low_sync = st_r.low_meta;

      // Threshold follows contrast only when linked
      if (st_r.vbm[lcdp_pkg::VBM_LINK]) begin
         st_nxt.thr_eff = (thr_sum > lcdp_pkg::THR_MAX) ?
                          lcdp_pkg::THR_MAX[4:0] : thr_sum[4:0];
      end else begin
         st_nxt.thr_eff = st_r.vbm[lcdp_pkg::THR_W-1:0];
      end

      // Wake request only from an enabled monitor and chosen source
      st_nxt.wake = st_r.aux[lcdp_pkg::AUX_WAKE] &&
                    st_r.vbm[lcdp_pkg::VBM_EN] && st_r.low_sync;

      // Shared bias generator runs while either consumer wants it
      st_nxt.gen_on = st_r.mscn[lcdp_pkg::MSCN_BIAS] ||
                      st_r.mscn[lcdp_pkg::MSCN_DCBIAS];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r.mscn <= lcdp_pkg::RST_MSCN;
         st_r.mscf <= lcdp_pkg::RST_MSCF[1:0];
         st_r.mode <= lcdp_pkg::RST_PWR[lcdp_pkg::PWR_MODE];
         st_r.vbm <= lcdp_pkg::RST_VBM;
         st_r.aux <= lcdp_pkg::RST_AUX;
         st_r.rdata <= 8'h00;
         st_r.low_meta <= 1'b0;
         st_r.low_sync <= 1'b0;
         st_r.thr_eff <= 5'h00;
         st_r.wake <= 1'b0;
         st_r.gen_on <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   lcdp_seg_store #(
      .SEG_COUNT(SEG_COUNT),
      .IDXW(IDXW)
   ) u_seg (
      .mclk(mclk),
      .rst(rst),
      .bus(seg_bus),
      .seg_flat(seg_data)
   );

   assign sfr_rdata = st_r.rdata;
   assign display_on = st_r.mscn[lcdp_pkg::MSCN_ON];
   assign display_clear = st_r.mscn[lcdp_pkg::MSCN_CLR];
   assign pump_low_drive = st_r.mscn[lcdp_pkg::MSCN_PUMP_LOW_DRIVE];
   assign lcd_clk_on = st_r.mscn[lcdp_pkg::MSCN_CLKOE];
   assign bias_on = st_r.mscn[lcdp_pkg::MSCN_BIAS];
   // Gating this also removes the buck converter's bias
   assign dc_bias_out = st_r.mscn[lcdp_pkg::MSCN_DCBIAS];
   assign bias_gen_on = st_r.gen_on;
   assign buck_sleep_keep = st_r.mscf[lcdp_pkg::MSCF_BUCK];
   assign pump_bypass = st_r.mscf[lcdp_pkg::MSCF_BYP];
   assign contrast_mode_hi = st_r.mode;
   assign mon_enable = st_r.vbm[lcdp_pkg::VBM_EN];
   assign thr_linked = st_r.vbm[lcdp_pkg::VBM_LINK];
   assign mon_threshold = st_r.thr_eff;
   assign wake_req = st_r.wake;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   clear_zeroes_a: assert property (
      (wr_mscn && sfr_wdata[lcdp_pkg::MSCN_CLR]) |=> (seg_data == '0))
      else $error("segment data not cleared after clear write");

   clear_holds_a: assert property (
      (display_clear && !wr_mscn) |=> display_clear)
      else $error("clear bit dropped without a write");

   enable_bit_a: assert property (
      wr_mscn |=> (display_on == $past(sfr_wdata[lcdp_pkg::MSCN_ON])))
      else $error("display enable does not follow write");

   low_drive_a: assert property (
      wr_mscn ##1 !wr_mscn |=>
      (pump_low_drive == $past(sfr_wdata[lcdp_pkg::MSCN_PUMP_LOW_DRIVE], 2)))
      else $error("pump drive bit not held from write");

   ctl_resv_a: assert property (
      (sfr_rd && sfr_addr == lcdp_pkg::ADDR_MSCN) |=>
      (sfr_rdata[7] == 1'b0 && sfr_rdata[3] == 1'b0))
      else $error("reserved control bits read nonzero");

   buck_keep_a: assert property (
      wr_mscf |=> (buck_sleep_keep == $past(sfr_wdata[1])))
      else $error("buck sleep bit does not follow write");

   pump_bypass_a: assert property (
      wr_mscf |=> (pump_bypass == $past(sfr_wdata[0])))
      else $error("pump bypass bit does not follow write");

   cfg_ones_a: assert property (
      (sfr_rd && sfr_addr == lcdp_pkg::ADDR_MSCF) |=>
      (sfr_rdata[7:2] == 6'h3f && sfr_rdata[1:0] == $past(st_r.mscf)))
      else $error("configuration read wrong");

   pwr_fixed_a: assert property (
      (sfr_rd && sfr_addr == lcdp_pkg::ADDR_PWR) |=>
      (sfr_rdata[7:4] == 4'h0 && sfr_rdata[2:0] == 3'h1 &&
       sfr_rdata[3] == $past(contrast_mode_hi)))
      else $error("power register read wrong");

   mode_sel_a: assert property (
      wr_pwr |=> (contrast_mode_hi == $past(sfr_wdata[3])))
      else $error("mode bit does not follow write");

   thr_free_a: assert property (
      !thr_linked |=> (mon_threshold == $past(st_r.vbm[4:0])))
      else $error("independent threshold not taken from field");

   thr_link_a: assert property (
      (thr_linked && contrast_code == 5'h00) |=>
      (mon_threshold == {2'b00, $past(st_r.aux[2:0])}))
      else $error("linked threshold offset wrong");

   wake_src_a: assert property (
      (st_r.low_sync && mon_enable && st_r.aux[lcdp_pkg::AUX_WAKE])
      |=> wake_req)
      else $error("wake request missing on battery low");

   bias_share_a: assert property (
      $past(dc_bias_out) |-> bias_gen_on)
      else $error("buck bias on while generator off");

   clear_pin_a: assert property (
      wr_mscn |=>
      (display_clear == $past(sfr_wdata[lcdp_pkg::MSCN_CLR])))
      else $error("clear bit does not follow write");

   clk_gate_a: assert property (
      wr_mscn |=>
      (lcd_clk_on == $past(sfr_wdata[lcdp_pkg::MSCN_CLKOE])))
      else $error("display clock gate does not follow write");

   ctl_hold_a: assert property (
      !wr_mscn |=>
      ($stable(display_on) && $stable(pump_low_drive)))
      else $error("control outputs moved without a write");

   cfg_hold_a: assert property (
      !wr_mscf |=>
      ($stable(buck_sleep_keep) && $stable(pump_bypass)))
      else $error("configuration outputs moved without a write");

   mode_hold_a: assert property (
      !wr_pwr |=>
      $stable(contrast_mode_hi))
      else $error("mode bit moved without a write");

   vbm_read_a: assert property (
      (sfr_rd && sfr_addr == lcdp_pkg::ADDR_VBM) |=>
      (sfr_rdata[5] == 1'b0 && sfr_rdata[6] == $past(thr_linked)))
      else $error("monitor control read wrong");

   unmapped_rd_a: assert property (
      (sfr_rd && !seg_hit && sfr_addr != lcdp_pkg::ADDR_MSCN &&
       sfr_addr != lcdp_pkg::ADDR_MSCF && sfr_addr != lcdp_pkg::ADDR_PWR &&
       sfr_addr != lcdp_pkg::ADDR_VBM && sfr_addr != lcdp_pkg::ADDR_AUX)
      |=> (sfr_rdata == 8'h00))
      else $error("unmapped address read nonzero");

   rdata_hold_a: assert property (
      !sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");

   thr_sat_a: assert property (
      (thr_linked && contrast_code == 5'h1f) |=>
      (mon_threshold == lcdp_pkg::THR_MAX[4:0]))
      else $error("linked threshold does not saturate");

   thr_raise_a: assert property (
      thr_linked |=> (mon_threshold >= $past(contrast_code)))
      else $error("linked threshold below contrast setting");

   wake_off_a: assert property (
      (!st_r.aux[lcdp_pkg::AUX_WAKE] || !mon_enable) |=> !wake_req)
      else $error("wake request from a source not chosen");

   bias_off_a: assert property (
      (!$past(dc_bias_out) && !$past(bias_on)) |-> !bias_gen_on)
      else $error("bias generator on with both consumers off");

   wake_sync_a: assert property (
      !st_r.low_sync |=> !wake_req)
      else $error("wake request before battery low synchronised");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the LCD power control register bank.
// Assumes lcdp_regs with a single-cycle register bus on mclk and the
// lcdp_pkg constants; a bench model tracks every register and byte.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int NSEG = lcdp_pkg::SEG_COUNT;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [4:0] contrast_code = 5'h00;
   logic batt_low = 1'b0;
   logic display_on, display_clear, pump_low_drive, lcd_clk_on, bias_on;
   logic dc_bias_out, bias_gen_on, buck_sleep_keep, pump_bypass;
   logic contrast_mode_hi, mon_enable, thr_linked, wake_req;
   logic [4:0] mon_threshold;
   logic [NSEG*8-1:0] seg_data;
   int num_errors = 0;
   int n_checks = 0;
   logic [31:0] rnd = 32'hfc1a188e;
   logic [7:0] m_pwr = 8'h09;
   logic [7:0] m_mscf = 8'hfe;
   logic [7:0] m_mscn = 8'h20;
   logic [7:0] m_vbm = 8'h00;
   logic [7:0] m_aux = 8'h00;
   logic [7:0] m_seg[NSEG] = '{default: 8'h00};
   logic [7:0] atab[7];

   lcdp_regs #(.SEG_COUNT(NSEG)) i_lcdp_regs (.mclk(mclk), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .contrast_code(contrast_code), .batt_low(batt_low),
      .display_on(display_on), .display_clear(display_clear),
      .pump_low_drive(pump_low_drive), .lcd_clk_on(lcd_clk_on),
      .bias_on(bias_on), .dc_bias_out(dc_bias_out),
      .bias_gen_on(bias_gen_on), .buck_sleep_keep(buck_sleep_keep),
      .pump_bypass(pump_bypass), .contrast_mode_hi(contrast_mode_hi),
      .mon_enable(mon_enable), .thr_linked(thr_linked),
      .mon_threshold(mon_threshold), .wake_req(wake_req),
      .seg_data(seg_data));

   always #5 mclk = ~mclk;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a >= lcdp_pkg::SEG_BASE && a < lcdp_pkg::SEG_BASE + 8'(NSEG))
         return m_seg[a - lcdp_pkg::SEG_BASE];
      case (a)
         lcdp_pkg::ADDR_PWR: return m_pwr;
         lcdp_pkg::ADDR_MSCF: return m_mscf;
         lcdp_pkg::ADDR_MSCN: return m_mscn;
         lcdp_pkg::ADDR_VBM: return m_vbm;
         lcdp_pkg::ADDR_AUX: return m_aux;
         default: return 8'h00;
      endcase
   endfunction

   task automatic chk_reg(input string n, input logic [7:0] e,
                          input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_seg(input logic [NSEG*8-1:0] g);
      logic [NSEG*8-1:0] e;
      for (int i = 0; i < NSEG; i++)
         e[8*i +: 8] = m_seg[i];
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] seg_data expected %h seen %h", e, g);
      end
   endtask

   // Every access starts and ends at a falling edge with an idle cycle,
   // so no strobe is driven twice in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
      case (a)
         lcdp_pkg::ADDR_PWR: m_pwr = (d & 8'h08) | 8'h01;
         lcdp_pkg::ADDR_MSCF: m_mscf = d | 8'hfc;
         lcdp_pkg::ADDR_MSCN: m_mscn = d & 8'h77;
         lcdp_pkg::ADDR_VBM: m_vbm = d & 8'hdf;
         lcdp_pkg::ADDR_AUX: m_aux = d & 8'h17;
         default:
            if (a >= lcdp_pkg::SEG_BASE && !m_mscn[1] &&
                a < lcdp_pkg::SEG_BASE + 8'(NSEG))
               m_seg[a - lcdp_pkg::SEG_BASE] = d;
      endcase
      if (m_mscn[1])
         m_seg = '{default: 8'h00};
      @(negedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
      @(negedge mclk);
   endtask

   // One extra cycle lets the threshold and bias-generator flops follow
   task automatic check_outs;
      logic [5:0] t;
      @(negedge mclk);
      t = m_vbm[6] ? 6'(contrast_code) + 6'(m_aux[2:0]) : 6'(m_vbm[4:0]);
      if (t > 6'd31)
         t = 6'd31;
      chk_reg("ctl_pins", m_mscn, {1'b0, bias_on, dc_bias_out,
         lcd_clk_on, 1'b0, pump_low_drive, display_clear, display_on});
      chk_reg("cfg_pins", {3'h0, m_vbm[7:6], m_pwr[3], m_mscf[1:0]},
         {3'h0, mon_enable, thr_linked, contrast_mode_hi, buck_sleep_keep,
          pump_bypass});
      chk_reg("bias_gen", {7'h0, m_mscn[6] | m_mscn[5]},
         {7'h0, bias_gen_on});
      chk_reg("threshold", {2'h0, t}, {3'h0, mon_threshold});
      chk_reg("wake", {7'h0, m_aux[4] & m_vbm[7] & batt_low},
         {7'h0, wake_req});
      chk_seg(seg_data);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200_000;
      num_errors++;
      complete_run();
   end

   initial begin
      logic [7:0] a;
      logic [7:0] got;
      logic [7:0] d;
      int k;
      atab = '{lcdp_pkg::ADDR_PWR, lcdp_pkg::ADDR_VBM, lcdp_pkg::ADDR_AUX,
               lcdp_pkg::ADDR_MSCN, lcdp_pkg::ADDR_MSCF, 8'h55,
               lcdp_pkg::SEG_BASE};
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      check_outs();
      foreach (atab[j]) begin
         rd(atab[j], got);
         chk_reg("reset_read", exp_rd(atab[j]), got);
      end
      $display("test reset values done");
      // Random writes cover unmapped space and the store; reserved
      // control bits, fixed configuration bits and the fixed power low field carry the values that software is obliged to write
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         k = rnd[2:0] % 7;
         a = atab[k];
         if (k == 6)
            a = a + {4'h0, rnd[11:8]};
         contrast_code = rnd[28:24];
         d = rnd[23:16];
         if (a == lcdp_pkg::ADDR_MSCN)
            d = d & lcdp_pkg::MSCN_MASK;
         if (a == lcdp_pkg::ADDR_MSCF)
            d = d | lcdp_pkg::MSCF_FIXED;
         if (a == lcdp_pkg::ADDR_PWR)
            d = (d & 8'hf8) | lcdp_pkg::PWR_FIXED;
         wr(a, d);
         rd(a, got);
         chk_reg("read_back", exp_rd(a), got);
         check_outs();
      end
      $display("test random access done");
      wr(lcdp_pkg::ADDR_MSCN, 8'h01);
      for (int i = 0; i < NSEG; i++) begin
         rnd = lfsr(rnd);
         wr(lcdp_pkg::SEG_BASE + 8'(i), rnd[7:0] | 8'h01);
      end
      check_outs();
      wr(lcdp_pkg::ADDR_MSCN, 8'h03);
      rd(lcdp_pkg::SEG_BASE + 8'h05, got);
      chk_reg("seg_after_clear", 8'h00, got);
      wr(lcdp_pkg::SEG_BASE + 8'h02, 8'haa);
      repeat (5) @(negedge mclk);
      check_outs();
      wr(lcdp_pkg::ADDR_MSCN, 8'h01);
      wr(lcdp_pkg::SEG_BASE + 8'h02, 8'haa);
      check_outs();
      $display("test display clear done");
      // Mode pair 2/3: bypass for mode 2, then reduced drive for mode 3
      wr(lcdp_pkg::ADDR_PWR, 8'h09);
      wr(lcdp_pkg::ADDR_MSCF, 8'hfd);
      check_outs();
      wr(lcdp_pkg::ADDR_MSCF, 8'hfe);
      wr(lcdp_pkg::ADDR_MSCN, 8'h05);
      check_outs();
      $display("test pump setup done");
      wr(lcdp_pkg::ADDR_AUX, 8'h17);
      wr(lcdp_pkg::ADDR_VBM, 8'hca);
      for (int i = 0; i < 32; i++) begin
         contrast_code = 5'(i);
         check_outs();
      end
      wr(lcdp_pkg::ADDR_VBM, 8'h8a);
      check_outs();
      $display("test threshold done");
      batt_low = 1'b1;
      repeat (2) @(negedge mclk);
      chk_reg("wake_early", 8'h00, {7'h0, wake_req});
      @(negedge mclk);
      chk_reg("wake_set", 8'h01, {7'h0, wake_req});
      wr(lcdp_pkg::ADDR_AUX, 8'h07);
      check_outs();
      batt_low = 1'b0;
      repeat (3) @(negedge mclk);
      check_outs();
      $display("test wake done");
      // Reset in mid-run returns every register and the store
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      m_pwr = lcdp_pkg::RST_PWR;
      m_mscf = lcdp_pkg::RST_MSCF;
      m_mscn = lcdp_pkg::RST_MSCN;
      m_vbm = lcdp_pkg::RST_VBM;
      m_aux = lcdp_pkg::RST_AUX;
      m_seg = '{default: lcdp_pkg::SEG_CLEAR};
      check_outs();
      foreach (atab[j]) begin
         rd(atab[j], got);
         chk_reg("rerst_read", exp_rd(atab[j]), got);
      end
      $display("test mid-run reset done");
      complete_run();
   end
endmodule
`default_nettype wire
